// ==== vrctd_pkg.sv ====
`default_nettype none
package vrctd_pkg;
    localparam int CLK_MHZ = 100;
    // phase length of each strobe step, covers the 15..25 ns holds
    localparam int T_PH_NS = 30;
    localparam int C_PH = (T_PH_NS * CLK_MHZ + 999) / 1000;
    // row precharge between cycles
    localparam int T_PRE_NS = 100;
    localparam int C_PRE = (T_PRE_NS * CLK_MHZ + 999) / 1000;
    // half period of the shift clock
    localparam int T_SCH_NS = 20;
    localparam int C_SCH = (T_SCH_NS * CLK_MHZ + 999) / 1000;
    // register byte offsets
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_ADDR = 5'h04;
    localparam logic [4:0] A_DATA = 5'h08;
    localparam logic [4:0] A_SHIFT = 5'h0C;
    // field positions
    localparam int B_CMD = 0;
    localparam int B_S1 = 3;
    localparam int B_S2 = 4;
    localparam int B_S3 = 5;
    localparam int B_GO = 8;
    localparam int B_CLR = 9;
    localparam int B_ROW = 9;
    localparam int B_D5 = 4;
    localparam int B_RDAT = 8;
    localparam int B_SGO = 8;
    localparam int B_SVAL = 4;
    typedef enum logic [2:0] {
        OP_WR = 3'h0, OP_RD = 3'h1, OP_REF = 3'h2, OP_XRD = 3'h3,
        OP_SPL = 3'h4, OP_XWR = 3'h5, OP_PSD = 3'h6, OP_AXW = 3'h7
    } vrctd_op_e;
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_SET = 7'h02, S_ROW = 7'h04, S_COL = 7'h08,
        S_WR = 7'h10, S_TG = 7'h20, S_PRE = 7'h40
    } vrctd_st_e;
endpackage
`default_nettype wire

// ==== vrctd_host.sv ====
// Behaviour
// - write-mask line high during refresh
// - pseudo transfer sets serial write mode
// - first serial bit after later clock edge
// - shift-clock gaps between split reloads
// - normal read transfer precedes first split
// - split only after tap edge of half
// - transfer gate high at non-transfer row fall
// - transfer gate high through late writes
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module vrctd_host
    import vrctd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic transfer_gate_n_o,
    output logic function_select_pin_o,
    output logic shift_port_gate_n_o,
    output logic [8:0] addr_o,
    output logic [3:0] dq_o,
    output logic dq_oe_o,
    input wire logic [3:0] dq_i,
    output logic shift_clock_o,
    output logic [3:0] shift_data_pins_o,
    output logic shift_data_pins_oe_o,
    input wire logic [3:0] shift_data_pins_i
);
    import vrctd_pkg::*;

    vrctd_st_e st_q, st_d;
    vrctd_op_e op_q, op_d;
    logic [3:0] cnt_q, cnt_d;
    logic [5:0] cfg_q, cfg_d;
    logic [8:0] row_q, row_d, col_q, col_d;
    logic [3:0] d4_q, d4_d, d5_q, d5_d, sout_q, sout_d;
    logic [3:0] rdat_q, rdat_d, sin_q, sin_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d, err_q, err_d, wmode_q, wmode_d;
    logic xrd_q, xrd_d, lspl_q, lspl_d, sval_q, sval_d;
    logic [1:0] since_q, since_d, sph_q, sph_d;
    logic [3:0] scnt_q, scnt_d;
    logic spend_q, spend_d;
    logic [3:0] dq_m, dq_s, sd_m, sd_s;
    logic acc, wr, go, clr, sgo, busy, split_ok, start, ras_fall, sc_rise;
    logic p_ras, p_cas, p_we, p_tg, p_fs, p_spg, p_oe, wrop, xfer;
    logic [8:0] p_addr;
    logic [3:0] p_dq;

    // two-stage synchronisers on data returned by the memory
    always_ff @(posedge clk_i)
    begin
        dq_m <= dq_i;
        dq_s <= dq_m;
        sd_m <= shift_data_pins_i;
        sd_s <= sd_m;
    end

    // wishbone slave: one wait state, unmapped reads give zero
    always_comb
    begin
        acc = wb_cyc_i & wb_stb_i & ~ack_q;
        wr = acc & wb_we_i;
        ack_d = acc;
        cfg_d = cfg_q;
        row_d = row_q;
        col_d = col_q;
        d4_d = d4_q;
        d5_d = d5_q;
        sout_d = sout_q;
        go = 1'b0;
        clr = 1'b0;
        sgo = 1'b0;
        dat_d = 32'h0;
        if (wb_adr_i == A_CTRL)
        begin
            if (wr && wb_sel_i[0])
                cfg_d = wb_dat_i[5:0];
            go = wr & wb_sel_i[1] & wb_dat_i[B_GO];
            clr = wr & wb_sel_i[1] & wb_dat_i[B_CLR];
            dat_d = {28'h0, sval_q, err_q, wmode_q, busy};
        end
        else if (wb_adr_i == A_ADDR)
        begin
            if (wr && wb_sel_i[1] && wb_sel_i[0])
                col_d = wb_dat_i[8:0];
            if (wr && wb_sel_i[2] && wb_sel_i[1])
                row_d = wb_dat_i[17:9];
            dat_d = {14'h0, row_q, col_q};
        end
        else if (wb_adr_i == A_DATA)
        begin
            if (wr && wb_sel_i[0])
            begin
                d4_d = wb_dat_i[3:0];
                d5_d = wb_dat_i[7:4];
            end
            dat_d = {20'h0, rdat_q, d5_q, d4_q};
        end
        else if (wb_adr_i == A_SHIFT)
        begin
            if (wr && wb_sel_i[0])
                sout_d = wb_dat_i[3:0];
            sgo = wr & wb_sel_i[1] & wb_dat_i[B_SGO];
            dat_d = {27'h0, sval_q, sin_q};
        end
        if (!acc || wb_we_i)
            dat_d = 32'h0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
            cfg_q <= 6'h00;
            row_q <= 9'h000;
            col_q <= 9'h000;
            d4_q <= 4'h0;
            d5_q <= 4'h0;
            sout_q <= 4'h0;
        end
        else
        begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            cfg_q <= cfg_d;
            row_q <= row_d;
            col_q <= col_d;
            d4_q <= d4_d;
            d5_q <= d5_d;
            sout_q <= sout_d;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // a split is legal only after a read transfer and enough shift edges
    assign split_ok = xrd_q & (since_q >= (lspl_q ? 2'h2 : 2'h1));
    assign busy = (st_q != S_IDLE) | (sph_q != 2'h0) | spend_q;
    // the command usually arrives in the same write as go, so look at its next value
    assign start = go & ~busy & ~(cfg_d[2:0] == OP_SPL && !split_ok);
    assign ras_fall = (st_q == S_SET) && (cnt_q == 4'h0);

    // cycle sequencer; shift clock is quiet whenever it runs
    always_comb
    begin
        st_d = st_q;
        op_d = op_q;
        cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
        rdat_d = rdat_q;
        wmode_d = wmode_q;
        xrd_d = xrd_q;
        lspl_d = lspl_q;
        err_d = err_q & ~clr;
        if (go && !start)
            err_d = 1'b1; // refusal wins over a same-cycle clear
        case (st_q)
            S_IDLE:
                if (start)
                begin
                    op_d = vrctd_op_e'(cfg_d[2:0]);
                    st_d = S_SET;
                    cnt_d = 4'(C_PH - 1);
                end
            S_SET:
                if (cnt_q == 4'h0)
                begin
                    st_d = S_ROW;
                    cnt_d = 4'(C_PH - 1);
                    if (op_q == OP_XRD)
                    begin
                        wmode_d = 1'b0;
                        xrd_d = 1'b1;
                        lspl_d = 1'b0;
                    end
                    else if (op_q == OP_SPL)
                        lspl_d = 1'b1;
                    else if (op_q == OP_XWR || op_q == OP_AXW || op_q == OP_PSD)
                        wmode_d = 1'b1;
                end
            S_ROW:
                if (cnt_q == 4'h0)
                begin
                    st_d = (op_q == OP_REF) ? S_PRE : S_COL;
                    cnt_d = (op_q == OP_REF) ? 4'(C_PRE - 1) : 4'(C_PH - 1);
                end
            S_COL:
                if (cnt_q == 4'h0)
                begin
                    if (op_q == OP_RD)
                        rdat_d = dq_s;
                    st_d = (op_q == OP_WR) ? S_WR : (op_q == OP_RD) ? S_PRE : S_TG;
                    cnt_d = (op_q == OP_RD) ? 4'(C_PRE - 1) : 4'(C_PH - 1);
                end
            S_WR, S_TG:
                if (cnt_q == 4'h0)
                begin
                    st_d = S_PRE;
                    cnt_d = 4'(C_PRE - 1);
                end
            S_PRE:
                if (cnt_q == 4'h0)
                    st_d = S_IDLE;
            default:
                st_d = S_IDLE;
        endcase
    end

    // pin levels follow the next state so they leave flip-flops
    always_comb
    begin
        wrop = (op_d == OP_WR);
        xfer = (op_d != OP_WR) && (op_d != OP_RD) && (op_d != OP_REF);
        p_ras = !(st_d inside {S_ROW, S_COL, S_WR, S_TG});
        p_cas = !(st_d inside {S_COL, S_WR, S_TG});
        p_addr = (st_d inside {S_SET, S_ROW}) ? row_q : col_q;
        p_tg = 1'b1;
        p_we = 1'b1;
        p_fs = 1'b0;
        p_spg = 1'b0;
        p_oe = 1'b0;
        p_dq = d5_q;
        if (st_d inside {S_SET, S_ROW})
        begin
            p_tg = ~xfer;
            if (wrop)
            begin
                p_we = cfg_q[B_S1];
                p_fs = cfg_q[B_S3];
                p_oe = 1'b1;
                p_dq = d4_q;
            end
            else if (op_d inside {OP_XWR, OP_AXW, OP_PSD})
                p_we = 1'b0;
            if (op_d inside {OP_SPL, OP_AXW})
                p_fs = 1'b1;
            if (op_d == OP_PSD)
                p_spg = 1'b1;
        end
        else if (st_d inside {S_COL, S_WR})
        begin
            if (wrop)
            begin
                p_we = 1'b0;
                p_fs = cfg_q[B_S2];
                p_oe = 1'b1;
            end
            p_tg = ~(xfer || op_d == OP_RD);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= S_IDLE;
            op_q <= OP_WR;
            cnt_q <= 4'h0;
            rdat_q <= 4'h0;
            err_q <= 1'b0;
            wmode_q <= 1'b0;
            xrd_q <= 1'b0;
            lspl_q <= 1'b0;
            ras_n_o <= 1'b1;
            cas_n_o <= 1'b1;
            we_n_o <= 1'b1;
            transfer_gate_n_o <= 1'b1;
            function_select_pin_o <= 1'b0;
            shift_port_gate_n_o <= 1'b0;
            addr_o <= 9'h000;
            dq_o <= 4'h0;
            dq_oe_o <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            rdat_q <= rdat_d;
            err_q <= err_d;
            wmode_q <= wmode_d;
            xrd_q <= xrd_d;
            lspl_q <= lspl_d;
            ras_n_o <= p_ras;
            cas_n_o <= p_cas;
            we_n_o <= p_we;
            transfer_gate_n_o <= p_tg;
            function_select_pin_o <= p_fs;
            shift_port_gate_n_o <= p_spg;
            addr_o <= p_addr;
            dq_o <= p_dq;
            dq_oe_o <= p_oe;
        end
    end

    // shift port: low half with data set up, high half, capture at end
    assign sc_rise = (sph_q == 2'h1) && (scnt_q == 4'h0);
    always_comb
    begin
        sph_d = sph_q;
        scnt_d = (scnt_q != 4'h0) ? scnt_q - 4'h1 : scnt_q;
        spend_d = spend_q | sgo;
        sin_d = sin_q;
        sval_d = sval_q;
        since_d = since_q;
        if (ras_fall && (op_q == OP_XRD || op_q == OP_SPL))
            since_d = 2'h0;
        else if (sc_rise && since_q != 2'h3)
            since_d = since_q + 2'h1;
        case (sph_q)
            2'h0:
                if (spend_q && st_q == S_IDLE)
                begin
                    spend_d = sgo;
                    sph_d = 2'h1;
                    scnt_d = 4'(C_SCH - 1);
                    sval_d = 1'b0;
                end
            2'h1:
                if (scnt_q == 4'h0)
                begin
                    sph_d = 2'h2;
                    scnt_d = 4'(C_SCH - 1);
                end
            2'h2:
                if (scnt_q == 4'h0)
                    sph_d = 2'h3; // one more cycle so the bit has crossed both sync stages
            default:
            begin
                sph_d = 2'h0;
                if (!wmode_q)
                begin
                    sin_d = sd_s;
                    sval_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sph_q <= 2'h0;
            scnt_q <= 4'h0;
            spend_q <= 1'b0;
            sin_q <= 4'h0;
            sval_q <= 1'b0;
            since_q <= 2'h0;
            shift_clock_o <= 1'b0;
            shift_data_pins_o <= 4'h0;
            shift_data_pins_oe_o <= 1'b0;
        end
        else
        begin
            sph_q <= sph_d;
            scnt_q <= scnt_d;
            spend_q <= spend_d;
            sin_q <= sin_d;
            sval_q <= sval_d;
            since_q <= since_d;
            shift_clock_o <= (sph_d == 2'h2);
            shift_data_pins_o <= sout_q;
            shift_data_pins_oe_o <= wmode_d;
        end
    end

    wr_mask_line_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(ras_n_o) && op_q == OP_WR |-> we_n_o == cfg_q[B_S1] && function_select_pin_o == cfg_q[B_S3])
        else $error("write line wrong at row fall");
    refresh_we_a: assert property (@(posedge clk_i) disable iff (rst_i)
        op_q == OP_REF && !ras_n_o |-> we_n_o)
        else $error("write line low in refresh");
    pseudo_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(ras_n_o) && op_q == OP_PSD |-> !transfer_gate_n_o && !we_n_o && !function_select_pin_o
        && shift_port_gate_n_o && !dq_oe_o ##[1:40] shift_data_pins_oe_o)
        else $error("pseudo transfer pins wrong");
    tg_plain_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(ras_n_o) && op_q inside {OP_WR, OP_RD, OP_REF} |-> transfer_gate_n_o)
        else $error("transfer gate low at plain row fall");
    late_wr_tg_a: assert property (@(posedge clk_i) disable iff (rst_i)
        op_q == OP_WR && !ras_n_o |-> transfer_gate_n_o)
        else $error("transfer gate low in write");
    split_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(ras_n_o) && op_q == OP_SPL |-> $past(since_q, 4) >= 2'h1)
        else $error("split without shift clock gap");
    split_init_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(ras_n_o) && op_q == OP_SPL |-> xrd_q)
        else $error("split before read transfer");
    quiet_sc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !transfer_gate_n_o |-> !shift_clock_o)
        else $error("shift clock during transfer");
endmodule
`default_nettype wire

// ==== vrctd_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module vrctd_mem_model
(
    input wire logic clk_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic tg_n_i,
    input wire logic fs_i,
    input wire logic gate_n_i,
    input wire logic shclk_i,
    input wire logic [8:0] addr_i,
    input wire logic [3:0] dq_i,
    input wire logic [3:0] sin_i,
    output logic [3:0] dq_o,
    output logic [3:0] sout_o
);
    logic [3:0] mem [0:2047];
    logic [3:0] sr [0:511];
    logic [3:0] mask = 4'h0, color = 4'h0, s4 = 4'h0, m, rdat = 4'h0, sv = 4'h0;
    logic r_q = 1'b1, c_q = 1'b1, k_q = 1'b0, s1, s3, xg, tx = 1'b0, wmode = 1'b0, rdv = 1'b0;
    logic [1:0] row = 2'h0;
    logic [8:0] ptr = 9'h000;
    logic [10:0] a;
    // a released line shows the inverse of its last value, never a kind guess
    assign dq_o = rdv ? rdat : ~rdat;
    assign sout_o = wmode ? ~sv : sv;
    // only four rows are kept, enough for the bench
    initial
        for (int i = 0; i < 2048; i++)
        begin
            mem[i] = 4'h0;
            sr[i % 512] = 4'h0;
        end
    // transfers decoded from the pin states latched at the row fall
    task xfer;
        if (!s1 && !s3 && xg)
            wmode = 1'b1;
        else if (!s1)
            for (int i = 0; i < 512; i++) mem[{row, i[8:0]}] = sr[i];
        else if (!s3)
        begin
            for (int i = 0; i < 512; i++) sr[i] = mem[{row, i[8:0]}];
            wmode = 1'b0;
            sv = ~sv;
        end
        else
            for (int i = 0; i < 256; i++) sr[{~ptr[8], i[7:0]}] = mem[{row, ~ptr[8], i[7:0]}];
        if (!(s1 && s3))
            ptr = addr_i;
    endtask
    // write modes from states 1 to 5
    task wrt;
        case ({s1, fs_i, s3})
            3'b101: mask = dq_i;
            3'b111: color = dq_i;
            default:
            begin
                if (!s1 && !s3)
                    mask = s4;
                m = s3 ? 4'hF : mask;
                if (!fs_i)
                    mem[a] = (mem[a] & ~m) | (dq_i & m);
                else
                    for (int i = 0; i < 4; i++)
                        if (dq_i[i]) mem[{a[10:2], i[1:0]}] = (mem[{a[10:2], i[1:0]}] & ~m) | (color & m);
            end
        endcase
    endtask
    // strobe edges are found against the previous sample of each pin; sampling
    // on the falling edge keeps the answers off the edge the host samples on
    always @(negedge clk_i)
    begin
        r_q <= ras_n_i;
        c_q <= cas_n_i;
        k_q <= shclk_i;
        if (ras_n_i)
            rdv = 1'b0;
        if (r_q && !ras_n_i)
        begin
            {s1, s3, s4, xg, row} = {we_n_i, fs_i, dq_i, gate_n_i, addr_i[1:0]};
            tx = !tg_n_i;
        end
        if (c_q && !cas_n_i)
        begin
            a = {row, addr_i};
            if (tx)
                xfer();
            else if (!we_n_i)
                wrt();
            else
                {rdv, rdat} = {1'b1, mem[a]};
        end
        if (!k_q && shclk_i)
        begin
            if (!wmode)
                sv = sr[ptr];
            else
                sr[ptr] = sin_i;
            ptr = ptr + 9'h001;
        end
    end
endmodule
`default_nettype wire

// ==== vrctd_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    import vrctd_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack;
    logic [4:0] adr;
    logic [31:0] dat, rdat, q;
    logic ras_n, cas_n, we_n, tg_n, fs, gate_n, shclk, dq_oe, ser_oe;
    logic [8:0] addr;
    logic [3:0] dq_h, dq_m, ser_h, ser_m;
    int fails = 0, num_checks = 0;
    // each shared line resolved from whichever side drives it
    wire logic [3:0] dq_w = dq_oe ? dq_h : dq_m;
    wire logic [3:0] ser_w = ser_oe ? ser_h : ser_m;
    vrctd_host u_vrctd_host (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .we_n_o(we_n), .transfer_gate_n_o(tg_n), .function_select_pin_o(fs), .shift_port_gate_n_o(gate_n),
        .addr_o(addr), .dq_o(dq_h), .dq_oe_o(dq_oe), .dq_i(dq_w), .shift_clock_o(shclk),
        .shift_data_pins_o(ser_h), .shift_data_pins_oe_o(ser_oe), .shift_data_pins_i(ser_w)
    );
    vrctd_mem_model u_vrctd_mem_model (
        .clk_i(clk_i), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .tg_n_i(tg_n), .fs_i(fs),
        .gate_n_i(gate_n), .shclk_i(shclk), .addr_i(addr), .dq_i(dq_w), .sin_i(ser_w), .dq_o(dq_m),
        .sout_o(ser_m)
    );
    // free running bench clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one classic cycle, held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        // no assumed latency: only the watchdog ends a missing answer
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    // start a sequencer command, then poll busy; q ends as the status word
    task automatic op(input logic [2:0] c, input logic [2:0] s);
        wb(1'b1, A_CTRL, {23'h0, 1'b1, 2'h0, s, c});
        do
            wb(1'b0, A_CTRL, 32'h0);
        while (q[0] !== 1'b0);
    endtask
    task automatic wr(input logic [2:0] s, input logic [3:0] s4, input logic [3:0] d5, input logic [8:0] col);
        wb(1'b1, A_ADDR, {14'h0, 9'h001, col});
        wb(1'b1, A_DATA, {24'h0, d5, s4});
        op(OP_WR, s);
    endtask
    task automatic rd(input logic [8:0] col);
        wb(1'b1, A_ADDR, {14'h0, 9'h001, col});
        op(OP_RD, 3'h0);
        wb(1'b0, A_DATA, 32'h0);
    endtask
    // one shift clock; the wait covers the fixed pulse and input sync
    task automatic sh(input logic [3:0] d);
        wb(1'b1, A_SHIFT, {23'h0, 1'b1, 4'h0, d});
        repeat (12) @(posedge clk_i);
        wb(1'b0, A_SHIFT, 32'h0);
    endtask
    // state patterns are {state3, state2, state1}; all on row 1
    task automatic t_wmodes;
        wr(3'b100, 4'h0, 4'h5, 9'h000);
        rd(9'h000);
        chk(q[11:8], 4'h5);
        wr(3'b000, 4'h3, 4'hA, 9'h000);
        rd(9'h000);
        chk(q[11:8], 4'h6);
        wr(3'b001, 4'h0, 4'hF, 9'h000);
        rd(9'h000);
        chk(q[11:8], 4'h7);
        wr(3'b111, 4'h0, 4'h9, 9'h000);
        wr(3'b110, 4'h0, 4'h5, 9'h004);
        rd(9'h006);
        chk(q[11:8], 4'h9);
        wr(3'b101, 4'h0, 4'h1, 9'h000);
        wr(3'b011, 4'h0, 4'h2, 9'h004);
        rd(9'h005);
        chk(q[11:8], 4'h1);
        wr(3'b010, 4'h8, 4'h8, 9'h004);
        rd(9'h007);
        chk(q[11:8], 4'h8);
        rd(9'h004);
        chk(q[11:8], 4'h9);
    endtask
    // refresh asked with state 1 low; the write line must still stay high
    task automatic t_ref;
        wb(1'b1, A_CTRL, 32'h102);
        repeat (30)
        begin
            @(posedge clk_i);
            if (ras_n === 1'b0)
                chk(we_n, 1'b1);
        end
    endtask
    task automatic t_serial;
        wb(1'b1, A_ADDR, {14'h0, 9'h002, 9'h008});
        op(OP_PSD, 3'h0);
        chk(q[1], 1'b1);
        chk(ser_oe, 1'b1);
        sh(4'hC);
        op(OP_XWR, 3'h0);
        wb(1'b1, A_ADDR, {14'h0, 9'h003, 9'h008});
        op(OP_AXW, 3'h0);
        chk(q[2], 1'b0);
        op(OP_XRD, 3'h0);
        chk(q[3:1], 3'h0);
        op(OP_SPL, 3'h0);
        chk(q[2], 1'b1);
        wb(1'b1, A_CTRL, 32'h200);
        sh(4'h0);
        chk(q[4:0], 5'h1C);
        op(OP_SPL, 3'h0);
        chk(q[2], 1'b0);
        wb(1'b1, A_ADDR, {14'h0, 9'h002, 9'h008});
        op(OP_XRD, 3'h0);
        sh(4'h0);
        chk(q[3:0], 4'hC);
    endtask
    // main sequence
    initial
    begin
        {rst_i, cyc, stb, we, adr, dat} = {1'b1, 3'b000, 5'h00, 32'h0};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({ras_n, cas_n, we_n, tg_n, shclk, dq_oe, ser_oe}, 7'h78);
        t_wmodes;
        t_ref;
        t_serial;
        complete_run;
    end
    // watchdog well beyond the expected run length
    initial
    begin
        #200000;
        fails++;
        complete_run;
    end
endmodule
`default_nettype wire
